// ### asc_pkg.sv
package asc_pkg;
  // Register word addresses on the slave port
  localparam logic [0:0]  ADDR_CONTROL   = 1'h0;
  localparam logic [0:0]  ADDR_STATUS    = 1'h1;
  // Control field positions
  localparam int          CTL_COUNT_MSB  = 19;
  localparam int          CTL_DUMMY_BIT  = 30;
  localparam int          CTL_START_BIT  = 31;
  // Status field positions
  localparam int          STS_DONE_BIT   = 0;
  localparam int          STS_OVF_BIT    = 1;
  localparam int          STS_OOR_BIT    = 2;
  // Reset values
  localparam logic [31:0] CONTROL_RESET  = 32'h0000_0000;
  localparam logic [2:0]  STATUS_RESET   = 3'h0;
  // Data path sizes
  localparam int          SAMPLE_W       = 14;
  localparam int          COUNT_W        = 20;
  localparam int          ADDR_W         = 32;
  localparam int          FIFO_DEPTH     = 16;
  localparam int          FIFO_AW        = 4;
  // Clock, address step and pattern step figures
  localparam int          CLOCK_MHZ      = 100;
  localparam logic [ADDR_W-1:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [SAMPLE_W-1:0] DUMMY_STEP = 14'h0001;

  typedef enum logic [1:0] {ASC_IDLE, ASC_RUN, ASC_DRAIN} asc_state_t;
endpackage

// ### asc_fifo.sv
module asc_fifo
  import asc_pkg::*;
#(
  parameter int W  = SAMPLE_W,
  parameter int D  = FIFO_DEPTH,
  parameter int AW = FIFO_AW
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         flush,
  input  wire logic         wr_valid,
  input  wire logic [W-1:0] wr_data,
  output logic              full,
  input  wire logic         rd_ready,
  output logic [W-1:0]      rd_data,
  output logic              empty
);
  logic [W-1:0] mem [D];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;

  assign full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign rd_data = mem[rd_ptr[AW-1:0]];

  // Storage; writes into a full FIFO are dropped
  always_ff @(posedge clock) begin
    if (wr_valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= wr_data;
    end
  end

  // Pointers
  always_ff @(posedge clock) begin
    if (rst || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (wr_valid && !full) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (rd_ready && !empty) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// ### asc_capture.sv
// Summary of operation
// - Control word: bits 19..0 sample count, bit 31 starts capture.
// - Control bit 30 substitutes generated counting data for converter samples.
// - After start, samples are taken every clock until count reached.
// - Each sample is pushed into an internal FIFO first; one arriving with the FIFO full is dropped.
// - FIFO drains to memory through master write transfers.
// - Processor reads control and status and writes control through the slave port; status is read-only.
// - Status bit 0 sets when the run ends and the FIFO has drained to memory, or at once for a zero count.
// - Status bit 1 sets when a sample arrives with FIFO full.
// - Status bit 2 sets when converter reports an out-of-range value on a sample taken without bit 30 set.
// - Whole block runs on one common system clock.
// - Each instance writes its own memory region via its base parameter.
// - Converter samples are 14-bit parallel words.
module asc_capture
  import asc_pkg::*;
#(
  parameter logic [ADDR_W-1:0] DEST_BASE = 32'h0000_0000
) (
  input  wire logic                clock,
  input  wire logic                rst,
  // Converter side
  input  wire logic [SAMPLE_W-1:0] adc_data,
  input  wire logic                adc_out_of_range,
  // Register slave port
  input  wire logic [0:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  output logic [31:0]              avs_readdata,
  // Memory master port
  output logic [ADDR_W-1:0]        avm_address,
  output logic                     avm_write,
  output logic [31:0]              avm_writedata,
  input  wire logic                avm_waitrequest
);
  asc_state_t           state;
  logic [31:0]          control;
  logic [2:0]           status;
  logic [COUNT_W-1:0]   taken;
  logic [COUNT_W-1:0]   stored;
  logic [SAMPLE_W-1:0]  dummy;
  logic [SAMPLE_W-1:0]  sample;
  logic                 sample_valid;
  logic                 fifo_full;
  logic                 fifo_empty;
  logic [SAMPLE_W-1:0]  fifo_data;
  logic                 pop;
  logic                 start;
  logic [COUNT_W-1:0]   req_count;

  // Single clock domain by design: converter is presumed already synchronous
  assign req_count    = control[CTL_COUNT_MSB:0];
  assign start        = avs_write && (avs_address == ADDR_CONTROL)
                        && avs_writedata[CTL_START_BIT];
  assign sample_valid = (state == ASC_RUN);
  assign sample       = control[CTL_DUMMY_BIT] ? dummy : adc_data;
  // A beat is retired once the master write is not stalled
  assign pop          = avm_write && !avm_waitrequest;

  asc_fifo u_fifo (
    .clock    (clock),
    .rst      (rst),
    .flush    (start),
    .wr_valid (sample_valid),
    .wr_data  (sample),
    .full     (fifo_full),
    .rd_ready (pop),
    .rd_data  (fifo_data),
    .empty    (fifo_empty)
  );

  // Control register; start bit self-clears when the run finishes
  always_ff @(posedge clock) begin
    if (rst) begin
      control <= CONTROL_RESET;
    end else if (avs_write && avs_address == ADDR_CONTROL) begin
      control <= avs_writedata;
    end else if (state == ASC_IDLE) begin
      control[CTL_START_BIT] <= 1'b0;
    end
  end

  // Capture sequencer: a zero count finishes at once
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ASC_IDLE;
      taken <= '0;
    end else if (start) begin
      taken <= '0;
      state <= (avs_writedata[CTL_COUNT_MSB:0] == '0) ? ASC_IDLE : ASC_RUN;
    end else begin
      unique case (state)
        ASC_IDLE: state <= ASC_IDLE;
        ASC_RUN: begin
          taken <= taken + 1'b1;
          if (taken + 1'b1 == req_count) begin
            state <= ASC_DRAIN;
          end
        end
        ASC_DRAIN: begin
          if (fifo_empty && !avm_write) begin
            state <= ASC_IDLE;
          end
        end
      endcase
    end
  end

  // Test pattern generator, restarts from zero on each capture
  always_ff @(posedge clock) begin
    if (rst || start) begin
      dummy <= '0;
    end else if (sample_valid) begin
      dummy <= dummy + DUMMY_STEP;
    end
  end

  // Memory master: one outstanding write, held until waitrequest drops
  always_ff @(posedge clock) begin
    if (rst || start) begin
      avm_write     <= 1'b0;
      avm_address   <= DEST_BASE;
      avm_writedata <= '0;
      stored        <= '0;
    end else if (avm_write) begin
      if (!avm_waitrequest) begin
        avm_write   <= 1'b0;
        avm_address <= avm_address + WORD_BYTES;
        stored      <= stored + 1'b1;
      end
    end else if (!fifo_empty) begin
      avm_write     <= 1'b1;
      avm_writedata <= {{(32-SAMPLE_W){fifo_data[SAMPLE_W-1]}}, fifo_data};
    end
  end

  // Sticky status; a fresh start outranks events and clears all flags, setting only done for a zero count
  always_ff @(posedge clock) begin
    if (rst) begin
      status <= STATUS_RESET;
    end else if (start) begin
      status <= STATUS_RESET;
      if (avs_writedata[CTL_COUNT_MSB:0] == '0) begin
        status[STS_DONE_BIT] <= 1'b1;
      end
    end else begin
      if (state == ASC_DRAIN && fifo_empty && !avm_write) begin
        status[STS_DONE_BIT] <= 1'b1;
      end
      if (sample_valid && fifo_full) begin
        status[STS_OVF_BIT] <= 1'b1;
      end
      if (sample_valid && !control[CTL_DUMMY_BIT] && adc_out_of_range) begin
        status[STS_OOR_BIT] <= 1'b1;
      end
    end
  end

  // Read data registered; zero wait states
  always_ff @(posedge clock) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if (avs_read) begin
      unique case (avs_address)
        ADDR_CONTROL: avs_readdata <= control;
        ADDR_STATUS:  avs_readdata <= {29'h0000_0000, status};
      endcase
    end
  end

  property p_start_clears;
    @(posedge clock) disable iff (rst)
      start |=> (status[STS_OVF_BIT] == 1'b0) && (status[STS_OOR_BIT] == 1'b0);
  endproperty
  AST_START_CLEARS: assert property (p_start_clears)
    else $error("status not cleared by start");

  AST_OVF_SET: assert property (
    @(posedge clock) disable iff (rst)
      (sample_valid && fifo_full && !start) |=> status[STS_OVF_BIT])
    else $error("overflow not flagged");

  AST_OOR_SET: assert property (
    @(posedge clock) disable iff (rst)
      (sample_valid && adc_out_of_range && !control[CTL_DUMMY_BIT] && !start)
      |=> status[STS_OOR_BIT])
    else $error("out of range not flagged");

  // Dropped samples never reach memory, so a run with overflow finishes short
  AST_DONE_CLEAN: assert property (
    @(posedge clock) disable iff (rst)
      $rose(status[STS_DONE_BIT])
      |-> fifo_empty && !avm_write && (status[STS_OVF_BIT] || stored == req_count))
    else $error("done before all stored");

  AST_ADDR_STEP: assert property (
    @(posedge clock) disable iff (rst)
      (pop && !start) |=> avm_address == $past(avm_address) + WORD_BYTES)
    else $error("address not stepped by one word");

  sequence s_stalled;
    avm_write && avm_waitrequest;
  endsequence
  AST_HOLD_WRITE: assert property (
    @(posedge clock) disable iff (rst)
      (s_stalled ##0 !start) |=> avm_write && $stable(avm_writedata))
    else $error("write dropped under waitrequest");

  AST_RUN_LENGTH: assert property (
    @(posedge clock) disable iff (rst)
      (state == ASC_RUN && !start && taken + 1'b1 == req_count) |=> state == ASC_DRAIN)
    else $error("run did not end at count");

  AST_STATUS_READ: assert property (
    @(posedge clock) disable iff (rst)
      (avs_read && avs_address == ADDR_STATUS)
      |=> avs_readdata == {29'h0000_0000, $past(status)})
    else $error("status read does not match flags");

  AST_DUMMY_COUNT: assert property (
    @(posedge clock) disable iff (rst)
      (sample_valid && control[CTL_DUMMY_BIT] && $past(sample_valid) && !$past(start))
      |-> sample == $past(sample) + DUMMY_STEP)
    else $error("dummy pattern not counting");
endmodule

// ### asc_adc_model.sv
// Behavioural converter: a ramp that moves every clock, so each
// captured word differs from its neighbour by a known step
module asc_adc_model
  import asc_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                oor_req,
  output logic [SAMPLE_W-1:0]      adc_data,
  output logic                     adc_out_of_range
);
  timeunit 1ns;
  timeprecision 1ns;
  initial adc_data = 14'h0000;
  // Changes just after the edge, never at it
  always @(posedge clock) begin
    adc_data <= #1 adc_data + 14'h0003;
  end
  assign adc_out_of_range = oor_req;
endmodule

// ### adc_sample_capture_to_memory_bench.sv
module adc_sample_capture_to_memory_bench;
  import asc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // Nonzero base shows the region comes from the parameter
  localparam logic [31:0] BASE = 32'h0000_1000;
  logic              clock = 1'b0;
  logic              rst = 1'b1;
  logic              oor_req = 1'b0;
  logic              stall = 1'b0;
  logic [0:0]        avs_address = 1'h0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [31:0]       avs_writedata = 32'h0000_0000;
  logic [31:0]       avs_readdata;
  logic [31:0]       avm_address;
  logic [31:0]       avm_writedata;
  logic              avm_write;
  logic [13:0]       adc_data;
  logic              adc_out_of_range;
  logic [31:0]       st;
  logic [31:0]       mem [0:63];
  logic [31:0]       last_addr = 32'h0000_0000;
  int                n_fail = 0;
  int                cmp_count = 0;
  int                wcnt = 0;

  always #20 clock = ~clock;

  asc_adc_model u_adc (.clock(clock), .oor_req(oor_req), .adc_data(adc_data),
                       .adc_out_of_range(adc_out_of_range));

  asc_capture #(.DEST_BASE(BASE)) u_dut (
    .clock(clock), .rst(rst), .adc_data(adc_data),
    .adc_out_of_range(adc_out_of_range), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avm_address(avm_address), .avm_write(avm_write),
    .avm_writedata(avm_writedata), .avm_waitrequest(stall));

  // Memory slave: stores each accepted write by word index
  always @(posedge clock) begin
    if (avm_write === 1'b1 && stall === 1'b0) begin
      mem[6'((avm_address - BASE) >> 2)] <= avm_writedata;
      last_addr <= avm_address;
      wcnt <= wcnt + 1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [0:0] a, input logic [31:0] d);
    @(negedge clock);
    avs_address = a;
    avs_writedata = d;
    avs_write = 1'b1;
    @(negedge clock);
    avs_write = 1'b0;
  endtask

  // Read data is registered, so it is taken one cycle after the strobe
  task automatic reg_rd(input logic [0:0] a, output logic [31:0] d);
    @(negedge clock);
    avs_address = a;
    avs_read = 1'b1;
    @(negedge clock);
    avs_read = 1'b0;
    d = avs_readdata;
  endtask

  // Bounded poll; a hang shows up as a wrong status value
  task automatic wait_done(output logic [31:0] s);
    s = 32'h0000_0000;
    for (int i = 0; i < 200 && s[0] !== 1'b1; i++) reg_rd(ADDR_STATUS, s);
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (10) @(negedge clock);
    rst = 1'b0;
    reg_rd(ADDR_CONTROL, st);
    chk(st, CONTROL_RESET);
    reg_rd(ADDR_STATUS, st);
    chk(st, 32'h0000_0000);
    reg_wr(ADDR_STATUS, 32'h0000_0007);
    reg_rd(ADDR_STATUS, st);
    chk(st, 32'h0000_0000);
    // Generated data, five samples
    reg_wr(ADDR_CONTROL, 32'hC000_0005);
    wait_done(st);
    chk(st, 32'h0000_0001);
    reg_rd(ADDR_CONTROL, st);
    chk(st, 32'h4000_0005);
    chk(32'(wcnt), 32'h0000_0005);
    // Fifth word lands four words above the instance base
    chk(last_addr, BASE + 32'h0000_0010);
    for (int i = 0; i < 5; i++) chk(mem[i], 32'(i));
    // Converter data with the range flag up
    oor_req = 1'b1;
    reg_wr(ADDR_CONTROL, 32'h8000_0004);
    wait_done(st);
    oor_req = 1'b0;
    chk(st, 32'h0000_0005);
    for (int i = 0; i < 3; i++) chk(mem[i+1] - mem[i], 32'h0000_0003);
    // Memory stalls long enough for the queue to fill
    stall = 1'b1;
    reg_wr(ADDR_CONTROL, 32'h8000_0028);
    repeat (40) @(negedge clock);
    stall = 1'b0;
    wait_done(st);
    chk(st, 32'h0000_0003);
    // Zero count restarts and must clear the stale flags
    reg_wr(ADDR_CONTROL, 32'h8000_0000);
    wait_done(st);
    chk(st, 32'h0000_0001);
    complete_run();
  end

  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    #1200000;
    n_fail++;
    complete_run();
  end
endmodule
